// ### hw/pin4_pwm_level_encoder.sv
// PWM level encoder for the pin 4 overcurrent alert pin with its APB register file.
`timescale 1ns/1ps
module pin4_pwm_level_encoder
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pin4_pwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [pin4_pwm_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pin4_level,
    output logic [pin4_pwm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pin4_overcurrent_alert_pin,
    output logic pin4_tick,
    output logic [pin4_pwm_pkg::TB_W-1:0] pin4_tick_select
);
    import pin4_pwm_pkg::*;

    // Bits 15:14 of the high-level register are unused and always read as zero.
    localparam logic [REG_W-1:0] HIGH_LEVEL_RST_TOP = 16'hc000;

    logic [REG_W-1:0] low_level_r;
    logic [REG_W-1:0] high_level_r;
    logic [REG_W-1:0] spare_r;
    logic [REG_W-1:0] crc_ref_r;
    logic [DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic out_r;
    logic tick_r;
    logic level_r;
    logic [TB_W-1:0] act_tb_r;
    logic [CNT_W-1:0] act_hc_r;
    logic [CNT_W-1:0] act_lc_r;
    logic [PRE_W-1:0] pre_cnt_r;
    logic [CNT_W-1:0] cnt_r;
    phase_t phase_r;

    logic setup;
    logic access;
    logic [7:0] idx;
    logic mapped;
    logic wr_low;
    logic wr_high;
    logic wr_spare;
    logic wr_crc;
    logic [REG_W-1:0] sel_pair;
    logic tick;
    logic static_mode;
    logic period_end;
    logic level_change;
    logic load;

    // Returns the register index, or an out-of-map index when the address is misaligned or its bits above the index are set.
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [7:0] r;
        r = a[IDX_SHIFT +: 8];
        if (a[1:0] != 2'b00 || a[ADDR_W-1:IDX_SHIFT+8] != '0)
        begin
            r = 8'h00;
        end
        return r;
    endfunction

    // Number of master clocks in one PWM tick for a select code.
    function automatic logic [PRE_W-1:0] tick_len(input logic [TB_W-1:0] tb);
        return TICK_BASE << {tb, 1'b0};
    endfunction

    // Merges a 16-bit register with a write under byte strobes.
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [DATA_W-1:0] d,
                                               input logic [3:0] s);
        logic [REG_W-1:0] r;
        r = old;
        if (s[0])
        begin
            r[7:0] = d[7:0];
        end
        if (s[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign idx = reg_index(paddr);
    assign mapped = idx == IDX_LOW_LEVEL || idx == IDX_HIGH_LEVEL || idx == IDX_SPARE
                    || idx == IDX_CRC_REF;
    assign wr_low = access && pwrite && !pslverr_r && idx == IDX_LOW_LEVEL;
    assign wr_high = access && pwrite && !pslverr_r && idx == IDX_HIGH_LEVEL;
    assign wr_spare = access && pwrite && !pslverr_r && idx == IDX_SPARE;
    assign wr_crc = access && pwrite && !pslverr_r && idx == IDX_CRC_REF;

    // Every access takes one wait-free access cycle; data and error are set up in the setup cycle.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            if (setup)
            begin
                case (idx)
                    IDX_LOW_LEVEL: prdata_r <= {16'h0000, low_level_r};
                    IDX_HIGH_LEVEL: prdata_r <= {16'h0000, high_level_r};
                    IDX_SPARE: prdata_r <= {16'h0000, spare_r};
                    IDX_CRC_REF: prdata_r <= {16'h0000, crc_ref_r};
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_level_r <= LOW_LEVEL_RST;
            high_level_r <= HIGH_LEVEL_RST;
        end
        else
        begin
            if (wr_low)
            begin
                low_level_r <= merge(low_level_r, pwdata, pstrb);
            end
            if (wr_high)
            begin
                high_level_r <= merge(high_level_r, pwdata, pstrb) & ~HIGH_LEVEL_RST_TOP;
            end
        end
    end

    // Spare and CRC reference are plain storage; nothing else reads them.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            spare_r <= SPARE_RST;
            crc_ref_r <= CRC_REF_RST;
        end
        else
        begin
            if (wr_spare)
            begin
                spare_r <= merge(spare_r, pwdata, pstrb);
            end
            if (wr_crc)
            begin
                crc_ref_r <= merge(crc_ref_r, pwdata, pstrb);
            end
        end
    end

    // Count pair chosen by the level being signalled.
    assign sel_pair = pin4_level ? high_level_r : low_level_r;
    assign tick = pre_cnt_r == tick_len(act_tb_r) - PRE_W'(1);
    assign static_mode = act_hc_r == '0 || act_lc_r == '0;
    assign level_change = pin4_level != level_r;
    assign period_end = tick && (static_mode
                        || (phase_r == PH_LOW && cnt_r == act_lc_r - CNT_W'(1)));
    assign load = level_change || period_end;

    // Settings are latched only at a period end or a level change; a level change cuts the running period short.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            level_r <= 1'b0;
            act_tb_r <= LOW_LEVEL_RST[TB_MSB:TB_LSB];
            act_hc_r <= LOW_LEVEL_RST[HC_MSB:HC_LSB];
            act_lc_r <= LOW_LEVEL_RST[LC_MSB:LC_LSB];
        end
        else
        begin
            level_r <= pin4_level;
            if (load)
            begin
                act_tb_r <= low_level_r[TB_MSB:TB_LSB];
                act_hc_r <= sel_pair[HC_MSB:HC_LSB];
                act_lc_r <= sel_pair[LC_MSB:LC_LSB];
            end
        end
    end

    // Prescaler counts master clocks within one tick; a boundary restarts it.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_cnt_r <= '0;
        end
        else if (load || tick)
        begin
            pre_cnt_r <= '0;
        end
        else
        begin
            pre_cnt_r <= pre_cnt_r + PRE_W'(1);
        end
    end

    // Phase sequencer counts ticks in the high and then the low phase.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_r <= PH_LOW;
            cnt_r <= '0;
        end
        else if (load)
        begin
            cnt_r <= '0;
            phase_r <= sel_pair[HC_MSB:HC_LSB] != '0 ? PH_HIGH : PH_LOW;
        end
        else if (tick)
        begin
            case (phase_r)
                PH_HIGH:
                begin
                    if (cnt_r == act_hc_r - CNT_W'(1))
                    begin
                        phase_r <= PH_LOW;
                        cnt_r <= '0;
                    end
                    else
                    begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                end
                PH_LOW:
                begin
                    cnt_r <= cnt_r + CNT_W'(1);
                end
                default:
                begin
                    phase_r <= PH_LOW;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // Pin level from the active pair; zero counts force a static level.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_r <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= tick;
            if (act_hc_r == '0)
            begin
                out_r <= 1'b0;
            end
            else if (act_lc_r == '0)
            begin
                out_r <= 1'b1;
            end
            else
            begin
                out_r <= phase_r == PH_HIGH;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin4_overcurrent_alert_pin = out_r;
    assign pin4_tick = tick_r;
    assign pin4_tick_select = act_tb_r;

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && pready;
    endsequence

    tick_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tick && !load |=> pre_cnt_r == '0 ##1 ($past(load) || pre_cnt_r == PRE_W'(1)))
        else $error("prescaler did not restart after a tick");

    tick_share_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tick |=> pin4_tick)
        else $error("shared tick pulse missing");

    high_phase_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tick && !load && phase_r == PH_HIGH && cnt_r == act_hc_r - CNT_W'(1)
        |=> phase_r == PH_LOW && cnt_r == '0)
        else $error("high phase did not end at the high count");

    low_phase_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tick && !static_mode && phase_r == PH_LOW && cnt_r == act_lc_r - CNT_W'(1)
        && sel_pair[HC_MSB:HC_LSB] != '0
        |=> cnt_r == '0 && phase_r == PH_HIGH)
        else $error("low phase did not end the period");

    static_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
        act_hc_r == '0 |=> !pin4_overcurrent_alert_pin)
        else $error("zero high count did not hold the pin low");

    static_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
        act_hc_r != '0 && act_lc_r == '0 |=> pin4_overcurrent_alert_pin)
        else $error("zero low count did not hold the pin high");

    pair_select_a: assert property (@(posedge core_clk) disable iff (!rstn)
        load |=> act_hc_r == $past(sel_pair[HC_MSB:HC_LSB])
                 && act_lc_r == $past(sel_pair[LC_MSB:LC_LSB]))
        else $error("wrong count pair latched");

    boundary_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !load |=> $stable(act_tb_r) && $stable(act_hc_r) && $stable(act_lc_r))
        else $error("settings changed inside a period");

    restart_a: assert property (@(posedge core_clk) disable iff (!rstn)
        level_change && sel_pair[HC_MSB:HC_LSB] != '0 |=> phase_r == PH_HIGH && cnt_r == '0)
        else $error("level change did not restart in the high phase");

    spare_rw_a: assert property (@(posedge core_clk) disable iff (!rstn)
        apb_setup_s ##1 (apb_access_s and (wr_spare && pstrb[1:0] == 2'b11))
        |=> spare_r == $past(pwdata[REG_W-1:0]))
        else $error("spare write not stored");

    unmapped_a: assert property (@(posedge core_clk) disable iff (!rstn)
        apb_setup_s and !mapped |=> pslverr && pready)
        else $error("unmapped access not refused");

    pre_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
        pre_cnt_r <= tick_len(act_tb_r) - PRE_W'(1))
        else $error("prescaler ran past the tick length");

    load_restart_a: assert property (@(posedge core_clk) disable iff (!rstn)
        load |=> pre_cnt_r == '0 && cnt_r == '0)
        else $error("boundary did not restart the counters");

    crc_rw_a: assert property (@(posedge core_clk) disable iff (!rstn)
        apb_setup_s ##1 (apb_access_s and (wr_crc && pstrb[1:0] == 2'b11))
        |=> crc_ref_r == $past(pwdata[REG_W-1:0]))
        else $error("reference write not stored");
endmodule // pin4_pwm_level_encoder

// ### hw/pin4_pwm_pkg.sv
// Package with the register map, field layout and timing constants of the pin 4 PWM encoder.
package pin4_pwm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CNT_W = 7;
    localparam int TB_W = 2;
    localparam int PRE_W = 11;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_LOW_LEVEL = 8'h57;
    localparam logic [7:0] IDX_HIGH_LEVEL = 8'h58;
    localparam logic [7:0] IDX_SPARE = 8'h59;
    localparam logic [7:0] IDX_CRC_REF = 8'h7e;
    localparam logic [1:0] IDX_SHIFT = 2'h2;
    // Field positions.
    localparam int TB_MSB = 15;
    localparam int TB_LSB = 14;
    localparam int HC_MSB = 13;
    localparam int HC_LSB = 7;
    localparam int LC_MSB = 6;
    localparam int LC_LSB = 0;
    // Reset values.
    localparam logic [REG_W-1:0] LOW_LEVEL_RST = 16'h007f;
    localparam logic [REG_W-1:0] HIGH_LEVEL_RST = 16'h3f80;
    localparam logic [REG_W-1:0] SPARE_RST = 16'h5555;
    localparam logic [REG_W-1:0] CRC_REF_RST = 16'h0000;
    // Tick length is TICK_BASE master clocks shifted left by two per select step.
    localparam logic [PRE_W-1:0] TICK_BASE = 11'h010;
    typedef enum logic {PH_HIGH, PH_LOW} phase_t;
endpackage

// ### tb/pwm_level_decoder.sv
// Far-side controller model that measures the phase lengths of the encoded pin.
`timescale 1ns/1ps
module pwm_level_decoder
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin,
    output int hi_len,
    output int lo_len
);
    logic prev_r;
    int run_r;

    // Each completed phase is stored as its length in clock cycles.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_r <= 1'b0;
            run_r <= 0;
            hi_len <= 0;
            lo_len <= 0;
        end
        else
        begin
            prev_r <= pin;
            if (pin !== prev_r)
            begin
                run_r <= 1;
                if (prev_r === 1'b1)
                    hi_len <= run_r;
                else
                    lo_len <= run_r;
            end
            else
                run_r <= run_r + 1;
        end
    end
endmodule // pwm_level_decoder

// ### tb/tb_top.sv
// Self-checking testbench for the pin 4 PWM level encoder.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
    import pin4_pwm_pkg::*;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pin4_level = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, pin, pin4_tick;
    logic [TB_W-1:0] pin4_tick_select;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [15:0] sv[6] = '{16'h0200, 16'h0000, 16'h0005, 16'h0000, 16'h0005, 16'h3f80};
    logic ex[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int err_total = 0, compares = 0, hi_len, lo_len, g, r1, r2, r3, r4;
    int seed = 32'h965c_5bc4;

    pin4_pwm_level_encoder uut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pin4_level(pin4_level), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin4_overcurrent_alert_pin(pin), .pin4_tick(pin4_tick),
        .pin4_tick_select(pin4_tick_select));
    pwm_level_decoder mon (.core_clk(core_clk), .rstn(rstn), .pin(pin), .hi_len(hi_len),
        .lo_len(lo_len));

    always #25 core_clk = ~core_clk;

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
        return ADDR_W'(i) << IDX_SHIFT;
    endfunction

    task automatic conclude();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A wait that ran out of its bound counts as a mismatch and ends the run.
    task automatic limit_hit(input logic hung);
        if (hung)
        begin
            err_total++;
            conclude();
        end
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic er, input logic [31:0] x);
        int n;
        n = 0;
        exp_q.push_back({!wr, er, x});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(negedge core_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        limit_hit(pready !== 1'b1);
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        apb(1'b1, ba(i), {16'h0000, d}, 4'hf, 1'b0, 32'h0000_0000);
    endtask

    task automatic rd(input logic [7:0] i, input logic [15:0] x);
        apb(1'b0, ba(i), 32'h0000_0000, 4'h0, 1'b0, {16'h0000, x});
    endtask

    task automatic tick_gap();
        g = 0;
        while (pin4_tick !== 1'b1 && g < 3000)
        begin
            @(negedge core_clk);
            g++;
        end
        limit_hit(pin4_tick !== 1'b1);
        @(negedge core_clk);
        g = 1;
        while (pin4_tick !== 1'b1 && g < 3000)
        begin
            @(negedge core_clk);
            g++;
        end
        limit_hit(pin4_tick !== 1'b1);
    endtask

    // Completed transfers are matched against the oldest note in order.
    always @(negedge core_clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            e = exp_q.pop_front();
            `CHK(pslverr, e[32])
            if (e[33])
                `CHK(prdata, e[31:0])
        end
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        rd(IDX_LOW_LEVEL, 16'h007f);
        rd(IDX_HIGH_LEVEL, 16'h3f80);
        rd(IDX_SPARE, 16'h5555);
        rd(IDX_CRC_REF, 16'h0000);
        apb(1'b0, ba(8'h5a), 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0000);
        apb(1'b1, 12'h15d, 32'h0000_1234, 4'hf, 1'b1, 32'h0000_0000);
        @(negedge core_clk);
        `CHK(pin, 1'b0)
        wr(IDX_SPARE, 16'ha5a5);
        apb(1'b1, ba(IDX_SPARE), 32'h0000_0000, 4'h1, 1'b0, 32'h0000_0000);
        rd(IDX_SPARE, 16'ha500);
        r1 = $random(seed);
        wr(IDX_CRC_REF, r1[15:0]);
        rd(IDX_CRC_REF, r1[15:0]);
        wr(IDX_HIGH_LEVEL, 16'hffff);
        rd(IDX_HIGH_LEVEL, 16'h3fff);
        for (int i = 0; i < 6; i++)
        begin
            // The pair is written before the level is set; only i == 3 switches the level and loads it at once, the others load it at the next tick.
            wr((i > 2) ? IDX_HIGH_LEVEL : IDX_LOW_LEVEL, sv[i]);
            @(posedge core_clk);
            pin4_level <= (i > 2);
            repeat (40) @(negedge core_clk);
            `CHK(pin, ex[i])
        end
        @(posedge core_clk);
        pin4_level <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            wr(IDX_LOW_LEVEL, {2'(s), 14'h0001});
            g = 0;
            while (pin4_tick_select !== 2'(s) && g < 3000)
            begin
                @(negedge core_clk);
                g++;
            end
            limit_hit(pin4_tick_select !== 2'(s));
            `CHK(pin4_tick_select, 2'(s))
            tick_gap();
            `CHK(g, 16 << (2 * s))
        end
        r1 = 1 + $unsigned($random(seed)) % 3;
        r2 = 1 + $unsigned($random(seed)) % 3;
        r3 = 1 + $unsigned($random(seed)) % 3;
        r4 = 1 + $unsigned($random(seed)) % 3;
        wr(IDX_LOW_LEVEL, {2'b01, 7'(r1), 7'(r2)});
        wr(IDX_HIGH_LEVEL, {2'b00, 7'(r3), 7'(r4)});
        repeat (2500) @(negedge core_clk);
        `CHK(hi_len, r1 * 64)
        `CHK(lo_len, r2 * 64)
        @(posedge core_clk);
        pin4_level <= 1'b1;
        repeat (1200) @(negedge core_clk);
        `CHK(hi_len, r3 * 64)
        `CHK(lo_len, r4 * 64)
        conclude();
    end
endmodule // tb_top
